/* src/master_clock_divider_select.sv */
// Purpose: derive master, cpu and system clocks from the crystal input
// Assumes: crystal_input is synchronous to sys_clk and well below half its rate
// Notes:   the loop path is a digital phase accumulator, not an analog loop
//
// The Wishbone register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "mclk_defines.svh"
`default_nettype none

module master_clock_divider_select (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  // oscillator in, clocks out
  input  wire logic        crystal_input,
  output var  logic        master_clock,
  output var  logic        cpu_clock,
  output var  logic        system_clock
);

  // how the master clock is made:
  //   bypass: a phase counter steps on every crystal edge, rising and falling,
  //   and the master clock is high for the first (idiv+1)*(odiv+1) steps of a period
  //   and low for as many; with both factors one it copies the crystal, duty included
  //   loop: a phase accumulator adds 2*(mul+1) per sys_clk and gives a vco edge each
  //   time it passes (idiv+1) measured crystal periods; the same counter then divides
  //   the vco edges by (odiv+1) per half period
  // limitations:
  //   the vco gives at most one edge per sys_clk, so its rate saturates there
  //   the loop path needs one rising crystal edge before it runs; that edge loads a period count measured from reset
  //   a stopped crystal freezes the master clock in bypass and keeps new settings pending; the loop runs on from the last measured period
  //   a reserved vco band is stored and flagged, with no other effect
  // all new settings, the cpu halving included, wait for a period boundary so
  // that, while bypass stays in force, neither the master nor the cpu clock ever shows a shortened level
  // register map, word addresses on wb_adr_i[7:2]:
  //   0x00 configuration: dividers, multiplier, vco band and clock source
  //   0x04 system configuration: cpu clock halving
  //   0x08 status, read only: crystal period, mode, flags, master level
  //   other addresses read zero and ignore writes; every request gets one ack

  // software-visible configuration
  logic [1:0]  input_divider_reg;
  logic [3:0]  output_divider_reg;
  logic [4:0]  feedback_multiplier_reg;
  logic [1:0]  vco_band_select_reg;
  logic [1:0]  clock_source_select_reg;
  logic        cpu_clock_halve_reg;

  // settings in force, loaded at a period boundary
  mclk_pkg::mode_type act_mode_reg;
  logic [1:0]  act_idiv_reg;
  logic [3:0]  act_odiv_reg;
  logic [4:0]  act_mul_reg;
  logic        act_halve_reg;

  // clock generation state
  logic        xtal_d_reg;
  logic [15:0] period_cnt_reg;
  logic [15:0] osc_period_reg;
  logic [23:0] acc_reg;
  logic [6:0]  phase_reg;
  logic        mclk_reg;
  logic        cpu_reg;
  logic        sys_reg;

  // bus state
  logic        ack_reg;
  logic [31:0] rdata_reg;

  // bus decode
  wire         bus_req    = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire         bus_wr     = bus_req & wb_we_i;
  wire         sel_ccr    = (wb_adr_i[7:2] == 6'(`CCR_OFFSET >> 2));
  wire         sel_syscfg = (wb_adr_i[7:2] == 6'(`SYSCFG_OFFSET >> 2));
  wire         sel_status = (wb_adr_i[7:2] == 6'(`STATUS_OFFSET >> 2));

  // current register images
  wire [31:0]  ccr_word;
  wire [31:0]  syscfg_word;
  wire [31:0]  status_word;
  wire [31:0]  ccr_merged;
  wire [31:0]  syscfg_merged;

  assign ccr_word = {14'h0000,
                     clock_source_select_reg,
                     vco_band_select_reg,
                     1'b0,
                     feedback_multiplier_reg,
                     output_divider_reg,
                     2'h0,
                     input_divider_reg};
  assign syscfg_word = {31'h00000000, cpu_clock_halve_reg};

  // source 0x is bypass, only 11 starts the loop path
  wire         mode_src_pll  = (clock_source_select_reg == `SRC_PLL);
  mclk_pkg::mode_type mode_from_src;
  assign mode_from_src = mode_src_pll ? mclk_pkg::MODE_PLL : mclk_pkg::MODE_BYPASS;

  // a written setting not yet in force; in bypass it stays up while the crystal is stopped
  wire         pend_idiv = (act_idiv_reg != input_divider_reg);
  wire         pend_odiv = (act_odiv_reg != output_divider_reg);
  wire         pend_mul  = (act_mul_reg != feedback_multiplier_reg);
  wire         pend_mode = (act_mode_reg != mode_from_src);
  wire         pending   = pend_idiv | pend_odiv | pend_mul | pend_mode;
  // the band only matters to an analog loop, so here it is just flagged
  wire         vb_bad  = (vco_band_select_reg == `VB_RESERVED);

  // the period field keeps its last value when the crystal stops
  assign status_word = {osc_period_reg,
                        12'h000,
                        act_mode_reg,
                        vb_bad,
                        pending,
                        mclk_reg};

  // byte lanes merge write data over the old word
  // reads always return the whole word; sel only masks writes
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
      assign ccr_merged[8*lane +: 8]    = wb_sel_i[lane] ? wb_dat_i[8*lane +: 8]
                                                         : ccr_word[8*lane +: 8];
      assign syscfg_merged[8*lane +: 8] = wb_sel_i[lane] ? wb_dat_i[8*lane +: 8]
                                                         : syscfg_word[8*lane +: 8];
    end
  endgenerate

  // fields of a write, output divider clipped at its top value
  // the input divider field is two bits wide, so it cannot pass three
  wire [3:0]   odiv_raw  = ccr_merged[`ODIV_MSB:`ODIV_LSB];
  wire [3:0]   odiv_wr   = (odiv_raw > `ODIV_MAX) ? `ODIV_MAX : odiv_raw;
  wire [1:0]   idiv_wr   = ccr_merged[`IDIV_MSB:`IDIV_LSB];

  // read mux; unmapped addresses read zero
  wire [31:0]  rdata_next = sel_ccr    ? ccr_word :
                            sel_syscfg ? syscfg_word :
                            sel_status ? status_word : 32'h00000000;

  // active division factors
  wire [2:0]   idiv_fac = {1'b0, act_idiv_reg} + 3'h1;
  wire [4:0]   odiv_fac = {1'b0, act_odiv_reg} + 5'h01;
  wire [7:0]   byp_fac  = idiv_fac * odiv_fac;
  wire         is_pll   = (act_mode_reg == mclk_pkg::MODE_PLL);
  wire [7:0]   half_len = is_pll ? {3'h0, odiv_fac} : byp_fac;
  wire [7:0]   last_ph  = {half_len[6:0], 1'b0} - 8'h01;

  // crystal edges
  wire         xtal_rise = crystal_input & ~xtal_d_reg;
  wire         xtal_fall = ~crystal_input & xtal_d_reg;
  wire         xtal_edge = xtal_rise | xtal_fall;

  // digital vco: one edge each time the accumulator passes an input period
  // threshold is (idiv+1) crystal periods, the step 2*(mul+1) per sys_clk
  wire [18:0]  vco_thr   = idiv_fac * osc_period_reg;
  wire [6:0]   vco_inc   = {1'b0, act_mul_reg, 1'b0} + 7'h02;
  wire [23:0]  acc_sum   = acc_reg + {17'h00000, vco_inc};
  wire         thr_ok    = (osc_period_reg != 16'h0000);
  wire         vco_edge  = is_pll & thr_ok & (acc_sum >= {5'h00, vco_thr});
  wire [23:0]  acc_diff  = acc_sum - {5'h00, vco_thr};
  // excess is dropped: the vco cannot give more than one edge per sys_clk
  wire [23:0]  acc_next  = ~is_pll ? 24'h000000 :
                           ~vco_edge ? acc_sum :
                           (acc_diff >= {5'h00, vco_thr}) ? 24'h000000 : acc_diff;

  // output prescaler steps on crystal edges in bypass and vco edges in loop mode
  // one phase register serves both paths, so a mode change needs no handover
  wire         step      = is_pll ? vco_edge : xtal_edge;
  wire         at_last   = ({1'b0, phase_reg} >= last_ph);
  // in bypass the wrap waits for a rising crystal edge so the phase stays aligned
  wire         wrap      = step & at_last & (is_pll | xtal_rise);
  wire [6:0]   phase_next = wrap ? 7'h00 :
                            (step & ~at_last) ? phase_reg + 7'h01 : phase_reg;
  wire         mclk_next = ({1'b0, phase_next} < half_len);
  wire         mclk_rise = mclk_next & ~mclk_reg;

  // the cpu divider halves by toggling on master rising edges
  // a new halving choice is taken only where cpu and master rise together;
  // switching at any other edge could leave the cpu clock with a short level
  wire         halve_load = mclk_rise & ~cpu_reg;
  wire         cpu_next  = act_halve_reg ? (mclk_rise ? ~cpu_reg : cpu_reg)
                                         : mclk_next;

  // period measurement counter saturates when the crystal stops
  wire [15:0]  period_inc = (period_cnt_reg == 16'hFFFF) ? period_cnt_reg
                                                         : period_cnt_reg + 16'h0001;

  // wishbone handshake: one wait state, ack drops the cycle after
  // read data is captured with the request and held until the next one
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      ack_reg   <= bus_req;
      rdata_reg <= bus_req ? rdata_next : rdata_reg;
    end
  end

  // configuration writes; status and unmapped writes are ignored
  // a written setting goes live only at the next wrap, below
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      input_divider_reg       <= `IDIV_RESET;
      output_divider_reg      <= `ODIV_RESET;
      feedback_multiplier_reg <= `MUL_RESET;
      vco_band_select_reg     <= `VB_RESET;
      clock_source_select_reg <= `SRC_RESET;
    end else if (bus_wr & sel_ccr) begin
      input_divider_reg       <= idiv_wr;
      output_divider_reg      <= odiv_wr;
      feedback_multiplier_reg <= ccr_merged[`MUL_MSB:`MUL_LSB];
      vco_band_select_reg     <= ccr_merged[`VB_MSB:`VB_LSB];
      clock_source_select_reg <= ccr_merged[`SRC_MSB:`SRC_LSB];
    end
  end

  // cpu halving bit as software sees it; the divider follows it later
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cpu_clock_halve_reg <= `HALVE_RESET;
    end else if (bus_wr & sel_syscfg) begin
      cpu_clock_halve_reg <= syscfg_merged[`HALVE_BIT];
    end
  end

  // halving in force, loaded where both clocks rise so no runt appears
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      act_halve_reg <= `HALVE_RESET;
    end else if (halve_load) begin
      act_halve_reg <= cpu_clock_halve_reg;
    end
  end

  // settings in force change only when the master clock starts a new period
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      act_mode_reg <= mclk_pkg::MODE_BYPASS;
      act_idiv_reg <= `IDIV_RESET;
      act_odiv_reg <= `ODIV_RESET;
      act_mul_reg  <= `MUL_RESET;
    end else if (wrap) begin
      act_mode_reg <= mode_from_src;
      act_idiv_reg <= input_divider_reg;
      act_odiv_reg <= output_divider_reg;
      act_mul_reg  <= feedback_multiplier_reg;
    end
  end

  // oscillator period in sys_clk cycles, the reference for the vco
  // one period is counted from rising crystal edge to rising crystal edge
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      xtal_d_reg     <= 1'b0;
      period_cnt_reg <= 16'h0000;
      osc_period_reg <= 16'h0000;
    end else begin
      xtal_d_reg     <= crystal_input;
      period_cnt_reg <= xtal_rise ? 16'h0001 : period_inc;
      osc_period_reg <= xtal_rise ? period_cnt_reg : osc_period_reg;
    end
  end

  // vco accumulator and output prescaler phase
  // the phase leaves reset on the last low step of a divide-by-one period,
  // so the master clock stays low until the first rising crystal edge
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      acc_reg   <= 24'h000000;
      phase_reg <= `PHASE_RESET;
    end else begin
      acc_reg   <= acc_next;
      phase_reg <= phase_next;
    end
  end

  // clock outputs, all from flip-flops
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      mclk_reg <= 1'b0;
      cpu_reg  <= 1'b0;
      sys_reg  <= 1'b0;
    end else begin
      mclk_reg <= mclk_next;
      cpu_reg  <= cpu_next;
      sys_reg  <= cpu_next;
    end
  end

  // port drivers
  assign wb_ack_o     = ack_reg;
  assign wb_dat_o     = rdata_reg;
  assign master_clock = mclk_reg;
  assign cpu_clock    = cpu_reg;
  assign system_clock = sys_reg;

endmodule : master_clock_divider_select

`default_nettype wire

/* src/mclk_defines.svh */
// Purpose: constants for the master clock divider and source selection block
// Assumes: 32-bit classic Wishbone slave, byte addresses on an 8-bit address
// Notes:   field positions and offsets are shared by the design and the bench
`ifndef MCLK_DEFINES_SVH
`define MCLK_DEFINES_SVH

// register byte offsets
`define CCR_OFFSET      8'h00
`define SYSCFG_OFFSET   8'h04
`define STATUS_OFFSET   8'h08

// clock_config_register fields
`define IDIV_LSB        0
`define IDIV_MSB        1
`define ODIV_LSB        4
`define ODIV_MSB        7
`define MUL_LSB         8
`define MUL_MSB         12
`define VB_LSB          14
`define VB_MSB          15
`define SRC_LSB         16
`define SRC_MSB         17

// field limits and encodings
`define ODIV_MAX        4'hE
`define VB_RESERVED     2'h3
`define SRC_PLL         2'h3

// reset values
`define IDIV_RESET      2'h0
`define ODIV_RESET      4'h0
`define MUL_RESET       5'h00
`define VB_RESET        2'h0
`define SRC_RESET       2'h0
`define HALVE_RESET     1'h0
`define PHASE_RESET     7'h01

// system config and status fields
`define HALVE_BIT       0
`define STAT_MCLK_BIT   0
`define STAT_PEND_BIT   1
`define STAT_VBRES_BIT  2
`define STAT_MODE_BIT   3
`define STAT_PER_LSB    16
`define STAT_PER_MSB    31

`endif

/* src/mclk_pkg.sv */
// Purpose: types for the master clock divider and source selection block
// Assumes: nothing beyond the defines header
// Notes:   the constants themselves live in mclk_defines.svh
package mclk_pkg;

  // path that produces the master clock
  typedef enum logic [0:0] {
    MODE_BYPASS = 1'b0,
    MODE_PLL    = 1'b1
  } mode_type;

endpackage : mclk_pkg

/* sim/mclk_checker_properties.sv */
// Purpose: port-level properties of the master clock block
// Assumes: the loop path is chosen once, last in a run
// Notes:   crystal edge relations hold only while bypass stays in force
`timescale 1ns/1ps
`default_nettype none
module mclk_checker (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        resetn,
  // register bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // clocks
  input wire logic        crystal_input,
  input wire logic        master_clock,
  input wire logic        cpu_clock,
  input wire logic        system_clock
);
  logic req;
  logic loop_wr;
  logic loop_reg;
  // request taken at this edge, and a write that selects the loop
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign loop_wr = req && wb_we_i && wb_adr_i[7:2] == 6'h00 && wb_dat_i[17:16] == 2'h3;
  // sticky: once the loop may run, edge timing no longer follows the crystal
  always_ff @(posedge sys_clk) begin
    if (!resetn) loop_reg <= 1'b0;
    else if (loop_wr && wb_sel_i[2]) loop_reg <= 1'b1;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  property p_ack_pulse; req |=> s_ack_pulse; endproperty
  property p_no_ack; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
  property p_unmapped; req && !wb_we_i && wb_adr_i[7:2] > 6'h02 |=> wb_dat_o == 32'h0;
  endproperty
  property p_dat_hold; wb_ack_o |=> $stable(wb_dat_o); endproperty
  property p_sys_cpu; system_clock == cpu_clock; endproperty
  property p_cpu_edge; $changed(cpu_clock) |-> $changed(master_clock); endproperty
  property p_byp_edge; !loop_reg && $changed(master_clock)
    |-> $past(crystal_input, 1) != $past(crystal_input, 2); endproperty
  property p_no_runt; !loop_reg && $changed(master_clock) |=> $stable(master_clock);
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack not a single pulse");
  a_no_ack: assert property (p_no_ack) else $error("ack without request");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_dat_hold: assert property (p_dat_hold) else $error("read data moved after ack");
  a_sys_cpu: assert property (p_sys_cpu) else $error("system clock differs");
  a_cpu_edge: assert property (p_cpu_edge) else $error("cpu clock edge alone");
  a_byp_edge: assert property (p_byp_edge) else $error("master edge off crystal");
  a_no_runt: assert property (p_no_runt) else $error("short master level");
endmodule : mclk_checker
bind master_clock_divider_select mclk_checker u_mclk_checker (.sys_clk(sys_clk),
  .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .crystal_input(crystal_input), .master_clock(master_clock),
  .cpu_clock(cpu_clock), .system_clock(system_clock));
`default_nettype wire

/* sim/osc_model.sv */
// Purpose: oscillator feeding the crystal input
// Assumes: half period given in sys_clk cycles, at least 2
// Notes:   stands low while stopped, so no stray edge at reset release
`timescale 1ns/1ps
`default_nettype none
module osc_model (
  // clock and control
  input  wire logic       sys_clk,
  input  wire logic       run,
  input  wire logic [7:0] half,
  // oscillator out
  output var  logic       crystal_input
);
  logic [7:0] cnt_reg;
  // toggle after each half period
  always_ff @(posedge sys_clk) begin
    if (!run) begin
      cnt_reg <= 8'h01;
      crystal_input <= 1'b0;
    end else if (cnt_reg >= half) begin
      cnt_reg <= 8'h01;
      crystal_input <= !crystal_input;
    end else cnt_reg <= cnt_reg + 8'h01;
  end
endmodule : osc_model
`default_nettype wire

/* sim/tb_master_clock_divider_select.sv */
// Purpose: self-checking bench for the master clock block
// Assumes: every task starts and ends just after a rising edge
// Notes:   levels sampled at the edge see the settled pre-edge value
`timescale 1ns/1ps
`include "mclk_defines.svh"
`default_nettype none
module tb_master_clock_divider_select;
  logic        sys_clk = 1'b0, resetn = 1'b0, cyc = 1'b0, we = 1'b0, run = 1'b0;
  logic [7:0]  adr = 8'h00, half = 8'h02;
  logic [3:0]  sel = 4'hF;
  logic [31:0] wdat = 32'h0, rd, dat_o;
  logic        ack, mclk, cpu_clk, sys_out, xtal;
  int          miscompares = 0, n_compared = 0, cycles = 0, hi, lo;
  always #5 sys_clk = !sys_clk;
  master_clock_divider_select u_master_clock_divider_select (.sys_clk(sys_clk),
    .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .crystal_input(xtal), .master_clock(mclk), .cpu_clock(cpu_clk), .system_clock(sys_out));
  osc_model u_osc_model (.sys_clk(sys_clk), .run(run), .half(half), .crystal_input(xtal));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one classic cycle, held until ack is seen at an edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge sys_clk); while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    @(posedge sys_clk);
  endtask : wb
  // new settings wait for a period boundary before they are in force
  task automatic wait_cfg;
    do wb(1'b0, `STATUS_OFFSET, 32'h0); while (rd[`STAT_PEND_BIT] !== 1'b0);
  endtask : wait_cfg
  task automatic lvl_len(input logic c, input logic lv, output int len);
    len = 0;
    while ((c ? cpu_clk : mclk) !== !lv) @(posedge sys_clk);
    while ((c ? cpu_clk : mclk) !== lv) @(posedge sys_clk);
    while ((c ? cpu_clk : mclk) === lv) begin
      @(posedge sys_clk);
      len++;
    end
  endtask : lvl_len
  task automatic t_regs;
    wb(1'b0, `CCR_OFFSET, 32'h0);
    check(rd, 32'h0);
    wb(1'b0, `STATUS_OFFSET, 32'h0);
    check(rd, 32'h0);
    wb(1'b1, 8'h0C, 32'hFFFF_FFFF);
    wb(1'b0, 8'h0C, 32'h0);
    check(rd, 32'h0);
    wb(1'b1, `CCR_OFFSET, 32'hFFFC_FFFF);
    wb(1'b0, `CCR_OFFSET, 32'h0);
    check(rd, 32'h0000_DFE3);
    wb(1'b1, `CCR_OFFSET, 32'h0);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_bypass;
    logic [1:0] iv[3] = '{2'h0, 2'h1, 2'h3};
    logic [3:0] ov[3] = '{4'h0, 4'h2, 4'hE};
    for (int k = 0; k < 3; k++) begin
      wb(1'b1, `CCR_OFFSET, {24'h0, ov[k], 2'h0, iv[k]});
      wait_cfg();
      lvl_len(1'b0, 1'b1, hi);
      lvl_len(1'b0, 1'b0, lo);
      check(hi, (iv[k] + 1) * (ov[k] + 1) * 2);
      check(lo, (iv[k] + 1) * (ov[k] + 1) * 2);
      check(cpu_clk, mclk);
    end
    $display("t_bypass done");
  endtask : t_bypass
  task automatic t_halve;
    wb(1'b1, `CCR_OFFSET, 32'h0000_0021);
    wait_cfg();
    wb(1'b1, `SYSCFG_OFFSET, 32'h1);
    wb(1'b0, `SYSCFG_OFFSET, 32'h0);
    check(rd, 32'h1);
    lvl_len(1'b1, 1'b1, hi);
    check(hi, 24);
    $display("t_halve done");
  endtask : t_halve
  task automatic t_loop;
    half <= 8'h04;
    repeat (40) @(posedge sys_clk);
    for (int b = 0; b < 4; b++) begin
      wb(1'b1, `CCR_OFFSET, 32'h0003_0110 | (b << 14));
      wb(1'b0, `CCR_OFFSET, 32'h0);
      check(rd, 32'h0003_0110 | (b << 14));
      wb(1'b0, `STATUS_OFFSET, 32'h0);
      check(rd[`STAT_VBRES_BIT], b == 3);
    end
    wait_cfg();
    check(rd[`STAT_MODE_BIT], 1'b1);
    check(rd[`STAT_PER_MSB:`STAT_PER_LSB], 32'h0000_0008);
    repeat (64) @(posedge sys_clk);
    lvl_len(1'b0, 1'b1, hi);
    lvl_len(1'b0, 1'b0, lo);
    check(hi + lo >= 7 && hi + lo <= 9, 1'b1);
    $display("t_loop done");
  endtask : t_loop
  task automatic finish_test;
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  // a hang ends the run as a mismatch
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      finish_test();
    end
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    t_regs();
    run <= 1'b1;
    t_bypass();
    t_halve();
    t_loop();
    finish_test();
  end
endmodule : tb_master_clock_divider_select
`default_nettype wire
